//--- core/commutator_pkg.sv
// shared types and constants for the six-step commutator
package commutator_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLOCK_HZ        = 50_000_000;
  localparam int unsigned TIMER_W         = 24;
  localparam int unsigned DEAD_NS         = 500;
  localparam int unsigned DEAD_CYCLES     =
    (DEAD_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PWM_W           = 10;
  localparam logic [PWM_W-1:0] PWM_PERIOD = 10'h3E7;

  // ----------------------------------------------------------------------
  // forced ramp defaults
  // ----------------------------------------------------------------------
  localparam int unsigned RAMP_START_US   = 20_000;
  localparam int unsigned RAMP_START_CYC  = RAMP_START_US * (CLOCK_HZ / 1_000_000);
  localparam int unsigned RAMP_END_US     = 2_000;
  localparam int unsigned RAMP_END_CYC    = RAMP_END_US * (CLOCK_HZ / 1_000_000);
  localparam int unsigned RAMP_SHIFT      = 5;
  localparam int unsigned BLANK_US        = 100;
  localparam int unsigned BLANK_CYC       = BLANK_US * (CLOCK_HZ / 1_000_000);
  localparam int unsigned LOCK_CROSSINGS  = 6;
  localparam int unsigned LOCK_W          = 3;

  // ----------------------------------------------------------------------
  // step encoding and phase drive
  // ----------------------------------------------------------------------
  localparam int unsigned NSTEPS          = 6;
  localparam logic [2:0]  STEP_AB         = 3'h0;
  localparam logic [2:0]  STEP_LAST       = 3'h5;

  typedef enum logic [1:0] {
    PH_FLOAT,
    PH_HIGH,
    PH_LOW
  } phase_drive_t;

  typedef struct packed {
    phase_drive_t a;
    phase_drive_t b;
    phase_drive_t c;
  } bridge_pattern_t;

  typedef struct packed {
    logic a_hi;
    logic a_lo;
    logic b_hi;
    logic b_lo;
    logic c_hi;
    logic c_lo;
  } gate_drive_t;

  localparam gate_drive_t GATES_OFF = 6'h00;

endpackage

//--- core/comparator_sync.sv
// two-stage synchroniser and edge detect for the three comparators
`timescale 1ns/1ps
`default_nettype none
module comparator_sync (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // comparator pins
  input  wire logic [2:0] comp_in,
  // synchronised levels and edges
  output logic      [2:0] comp_level,
  output logic      [2:0] comp_rise,
  output logic      [2:0] comp_fall
);

  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic [2:0] last_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
      last_reg <= 3'h0;
    end else begin
      meta_reg <= comp_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign comp_level = sync_reg;
  assign comp_rise  = sync_reg & ~last_reg;
  assign comp_fall  = ~sync_reg & last_reg;

endmodule
`default_nettype wire

//--- core/deadband_pair.sv
// one complementary high/low gate pair with deadband and trip
`timescale 1ns/1ps
`default_nettype none
module deadband_pair
  import commutator_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // control
  input  wire logic enable,
  input  wire logic want_high,
  input  wire logic trip,
  // gates
  output logic      gate_hi,
  output logic      gate_lo
);

  // ----------------------------------------------------------------------
  // deadband counter
  // ----------------------------------------------------------------------
  logic       state_reg;
  logic       state_next;
  logic [7:0] dead_reg;
  logic [7:0] dead_next;
  logic       hi_reg;
  logic       hi_next;
  logic       lo_reg;
  logic       lo_next;

  always_comb begin
    state_next = state_reg;
    dead_next  = dead_reg;
    hi_next    = 1'b0;
    lo_next    = 1'b0;
    if (!enable) begin
      dead_next = 8'(DEAD_CYCLES);
    end else if (want_high != state_reg) begin
      // both off while the other switch turns off
      state_next = want_high;
      dead_next  = 8'(DEAD_CYCLES);
    end else if (dead_reg != 8'h00) begin
      dead_next = dead_reg - 8'h01;
    end else begin
      hi_next = state_reg;
      lo_next = !state_reg;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= 1'b0;
      dead_reg  <= 8'h00;
      hi_reg    <= 1'b0;
      lo_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      dead_reg  <= dead_next;
      hi_reg    <= hi_next;
      lo_reg    <= lo_next;
    end
  end

  // trip gates the registered outputs combinationally so it acts at once
  assign gate_hi = hi_reg & !trip; // [RL14]
  assign gate_lo = lo_reg & !trip; // [RL14]

endmodule
`default_nettype wire

//--- core/sensorless_six_step_commutator.sv
// six-step sensorless commutation sequencer with forced start-up ramp
//
// Notes on behaviour
// [RL1] advance energization every sixty electrical degrees
// [RL2] two phases driven, third left floating
// [RL3] order AB AC BC BA CA CB, wrap
// [RL4] watch only floating phase for crossing
// [RL5] ramp timer steps open-loop until crossings
// [RL6] ramp period shortens non-linearly
// [RL7] switch half a step after crossing
// [RL8] comparator outputs index the commutation table; code indexes it by step_reg and checks the floating comparator
// [RL9] outside network compares phases to shared reference
// [RL10] reference sits at half bus voltage
// [RL11] expected crossing polarity depends on step, direction
// [RL12] direction reverses sequence and comparator table
// [RL13] three complementary pairs with deadband
// [RL14] fault trip forces PWM inactive at once
// [RL15] interval timer halves last commutation period
// [RL16] crossing loads delay timer, rollover commutates
// [RL17] reset: outputs inactive, step at AB
// [RL18] blank comparator edges just after commutation
`timescale 1ns/1ps
`default_nettype none
module sensorless_six_step_commutator
  import commutator_pkg::*;
#(
  parameter logic [TIMER_W-1:0] RAMP_START = TIMER_W'(RAMP_START_CYC),
  parameter logic [TIMER_W-1:0] RAMP_END   = TIMER_W'(RAMP_END_CYC)
) (
  // clock and reset
  input  wire logic                         clock,
  input  wire logic                         nrst,
  // control
  input  wire logic                         start,
  input  wire logic                         stop,
  input  wire logic                         reverse,
  input  wire logic [PWM_W-1:0]             duty,
  input  wire logic [TIMER_W-1:0]           blank_cycles,
  // fault trip pin
  input  wire logic                         fault_trip,
  // comparator pins, bit 0 phase a
  input  wire logic [2:0]                   comp_in,
  // bridge gates
  output commutator_pkg::gate_drive_t       gates,
  // status
  output logic                              running,
  output logic                              locked,
  output logic [2:0]                        step,
  output logic                              commutate
);

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] comp_level;
  logic [2:0] comp_rise;
  logic [2:0] comp_fall;
  logic       trip_meta_reg;
  logic       trip_sync_reg;
  logic       trip;

  comparator_sync u_sync (
    .clock      (clock),
    .nrst       (nrst),
    .comp_in    (comp_in),
    .comp_level (comp_level),
    .comp_rise  (comp_rise),
    .comp_fall  (comp_fall)
  );

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      trip_meta_reg <= 1'b0;
      trip_sync_reg <= 1'b0;
    end else begin
      trip_meta_reg <= fault_trip;
      trip_sync_reg <= trip_meta_reg;
    end
  end

  // raw pin only gates the outputs; state logic reads the synced copy
  assign trip = fault_trip | trip_sync_reg; // [RL14]

  // ----------------------------------------------------------------------
  // commutation tables
  // ----------------------------------------------------------------------
  function automatic bridge_pattern_t pattern_of(input logic [2:0] s);
    bridge_pattern_t p;
    p = '{PH_FLOAT, PH_FLOAT, PH_FLOAT};
    unique case (s) // [RL2] [RL3]
      3'h0:    p = '{PH_HIGH,  PH_LOW,   PH_FLOAT};
      3'h1:    p = '{PH_HIGH,  PH_FLOAT, PH_LOW};
      3'h2:    p = '{PH_FLOAT, PH_HIGH,  PH_LOW};
      3'h3:    p = '{PH_LOW,   PH_HIGH,  PH_FLOAT};
      3'h4:    p = '{PH_LOW,   PH_FLOAT, PH_HIGH};
      3'h5:    p = '{PH_FLOAT, PH_LOW,   PH_HIGH};
      default: p = '{PH_FLOAT, PH_FLOAT, PH_FLOAT};
    endcase
    return p;
  endfunction

  // floating phase index per step
  function automatic logic [1:0] float_of(input logic [2:0] s);
    logic [1:0] f;
    f = 2'h0;
    unique case (s) // [RL4]
      3'h0, 3'h3: f = 2'h2;
      3'h1, 3'h4: f = 2'h1;
      default:    f = 2'h0;
    endcase
    return f;
  endfunction

  // forward: floating phase rises on odd-numbered pattern positions
  // [RL11] [RL12] reverse runs the table backwards, so polarity flips
  function automatic logic rising_of(input logic [2:0] s,
                                     input logic       rev);
    return s[0] ^ rev;
  endfunction

  // next step from the current step and direction alone, wrapping between STEP_LAST and STEP_AB
  function automatic logic [2:0] next_of(input logic [2:0] s,
                                         input logic       rev);
    logic [2:0] n;
    n = 3'h0;
    if (rev) begin
      n = (s == STEP_AB) ? STEP_LAST : s - 3'h1;
    end else begin
      n = (s == STEP_LAST) ? STEP_AB : s + 3'h1;
    end
    return n;
  endfunction

  // ----------------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RAMP,
    ST_BEMF
  } run_state_t;

  run_state_t         state_reg,     state_next;
  logic [2:0]         step_reg,      step_next;
  logic [TIMER_W-1:0] ramp_per_reg,  ramp_per_next;
  logic [TIMER_W-1:0] ramp_cnt_reg,  ramp_cnt_next;
  logic [TIMER_W-1:0] ival_reg,      ival_next;
  logic [TIMER_W-1:0] half_reg,      half_next;
  logic [TIMER_W-1:0] delay_reg,     delay_next;
  logic               delay_on_reg,  delay_on_next;
  logic [TIMER_W-1:0] blank_reg,     blank_next;
  logic [LOCK_W-1:0]  lock_reg,      lock_next;
  logic               comm_reg,      comm_next;

  logic [1:0]         fl;
  logic               want_rise;
  logic               edge_seen;
  logic               crossing;
  logic               comm_now;

  always_comb begin
    fl        = float_of(step_reg);
    want_rise = rising_of(step_reg, reverse);
    edge_seen = want_rise ? comp_rise[fl] : comp_fall[fl]; // [RL4] [RL11]
    // confirm against the table level so a noisy wrong edge is dropped
    crossing  = edge_seen && (comp_level[fl] == want_rise) // [RL8]
                && (blank_reg == '0) && !delay_on_reg;     // [RL18]
  end

  always_comb begin
    state_next    = state_reg;
    step_next     = step_reg;
    ramp_per_next = ramp_per_reg;
    ramp_cnt_next = ramp_cnt_reg;
    ival_next     = ival_reg + TIMER_W'(1);
    half_next     = half_reg;
    delay_next    = delay_reg;
    delay_on_next = delay_on_reg;
    blank_next    = (blank_reg != '0) ? blank_reg - TIMER_W'(1) : blank_reg;
    lock_next     = lock_reg;
    comm_now      = 1'b0;

    unique case (state_reg)
      ST_IDLE: begin
        step_next = STEP_AB; // [RL17]
        ival_next = '0;
        if (start && !stop && !trip_sync_reg) begin
          state_next    = ST_RAMP;
          ramp_per_next = RAMP_START;
          ramp_cnt_next = RAMP_START;
          blank_next    = blank_cycles;
        end
      end
      ST_RAMP: begin
        // forced ramp timer counts down one step period
        if (ramp_cnt_reg <= TIMER_W'(1)) begin // [RL5]
          comm_now = 1'b1;
          // period shrinks by a fraction of itself: geometric, so
          // the period falls near linearly in time down to RAMP_END
          if (ramp_per_reg > RAMP_END) begin // [RL6]
            ramp_per_next = ramp_per_reg - (ramp_per_reg >> RAMP_SHIFT);
          end
          ramp_cnt_next = ramp_per_next;
        end else begin
          ramp_cnt_next = ramp_cnt_reg - TIMER_W'(1);
        end
        if (crossing) begin
          lock_next = (lock_reg == LOCK_W'(LOCK_CROSSINGS - 1)) ?
                      lock_reg : lock_reg + LOCK_W'(1);
          if (lock_reg == LOCK_W'(LOCK_CROSSINGS - 1)) begin
            // hand over: arm the delay from the ramp's own timing
            state_next    = ST_BEMF;
            delay_next    = half_reg; // [RL16]
            delay_on_next = 1'b1;
          end
        end
      end
      ST_BEMF: begin
        if (crossing) begin
          delay_next    = half_reg; // [RL16] [RL7]
          delay_on_next = 1'b1;
        end else if (delay_on_reg) begin
          if (delay_reg <= TIMER_W'(1)) begin
            delay_on_next = 1'b0;
            comm_now      = 1'b1; // [RL16]
          end else begin
            delay_next = delay_reg - TIMER_W'(1);
          end
        end
        // a lost rotor shows as no crossing for two ramp-end periods
        if (ival_reg > (RAMP_END << 1)) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase

    if (comm_now) begin
      step_next  = next_of(step_reg, reverse); // [RL1] [RL3] [RL12]
      ival_next  = '0; // [RL15]
      half_next  = ival_reg >> 1; // [RL15] [RL7]
      blank_next = blank_cycles; // [RL18]
    end

    if (stop || trip_sync_reg) begin
      state_next    = ST_IDLE;
      delay_on_next = 1'b0;
      lock_next     = '0;
    end
    comm_next = comm_now;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= ST_IDLE;
      step_reg     <= STEP_AB; // [RL17]
      ramp_per_reg <= '0;
      ramp_cnt_reg <= '0;
      ival_reg     <= '0;
      half_reg     <= '0;
      delay_reg    <= '0;
      delay_on_reg <= 1'b0;
      blank_reg    <= '0;
      lock_reg     <= '0;
      comm_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      step_reg     <= step_next;
      ramp_per_reg <= ramp_per_next;
      ramp_cnt_reg <= ramp_cnt_next;
      ival_reg     <= ival_next;
      half_reg     <= half_next;
      delay_reg    <= delay_next;
      delay_on_reg <= delay_on_next;
      blank_reg    <= blank_next;
      lock_reg     <= lock_next;
      comm_reg     <= comm_next;
    end
  end

  // ----------------------------------------------------------------------
  // pwm carrier
  // ----------------------------------------------------------------------
  logic [PWM_W-1:0] pwm_cnt_reg;
  logic [PWM_W-1:0] pwm_cnt_next;
  logic             pwm_on;

  always_comb begin
    pwm_cnt_next = (pwm_cnt_reg >= PWM_PERIOD) ? '0 :
                   pwm_cnt_reg + PWM_W'(1);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pwm_cnt_reg <= '0;
    end else begin
      pwm_cnt_reg <= pwm_cnt_next;
    end
  end

  assign pwm_on = (pwm_cnt_reg < duty);

  // ----------------------------------------------------------------------
  // gate drive: complementary pairs with deadband
  // ----------------------------------------------------------------------
  bridge_pattern_t pat;
  phase_drive_t    ph   [3];
  logic      [2:0] g_hi;
  logic      [2:0] g_lo;
  logic            drive_on;

  assign pat      = pattern_of(step_reg);
  assign ph[0]    = pat.a;
  assign ph[1]    = pat.b;
  assign ph[2]    = pat.c;
  assign drive_on = (state_reg != ST_IDLE); // [RL17]

  for (genvar i = 0; i < 3; i++) begin : g_pair
    // high phase chops complementary; low phase holds its low switch on
    deadband_pair u_pair ( // [RL13]
      .clock     (clock),
      .nrst      (nrst),
      .enable    (drive_on && (ph[i] != PH_FLOAT)), // [RL2]
      .want_high ((ph[i] == PH_HIGH) && pwm_on),
      .trip      (trip), // [RL14]
      .gate_hi   (g_hi[i]),
      .gate_lo   (g_lo[i])
    );
  end

  assign gates     = '{g_hi[0], g_lo[0], g_hi[1], g_lo[1], g_hi[2], g_lo[2]};
  assign running   = drive_on;
  assign locked    = (state_reg == ST_BEMF);
  assign step      = step_reg;
  assign commutate = comm_reg;

endmodule
`default_nettype wire

//--- tb/bridge_motor_model.sv
// bridge and spinning motor with back-emf comparators
`timescale 1ns/1ps
`default_nettype none
module bridge_motor_model
  import commutator_pkg::*;
(
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        nrst,
  // cycles from seen commutation to crossing, zero gives none
  input  wire logic [11:0]                 cross_delay,
  // bridge side
  input  wire commutator_pkg::gate_drive_t gates,
  output logic [2:0]                       comp_in
);
  logic [2:0]  hi;
  logic [2:0]  on;
  logic [2:0]  flt;
  logic [2:0]  flt_q;
  logic [2:0]  was_high;
  logic [11:0] wait_cnt;
  logic [7:0]  off_cnt [3];

  assign hi = {gates.c_hi, gates.b_hi, gates.a_hi};
  assign on = hi | {gates.c_lo, gates.b_lo, gates.a_lo};
  // longer off than a deadband means the phase really floats
  always_comb
    for (int i = 0; i < 3; i++) flt[i] = off_cnt[i] > 8'd40;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      off_cnt  <= '{default: 8'h00};
      flt_q    <= 3'h7;
      was_high <= 3'h0;
      comp_in  <= 3'h0;
      wait_cnt <= 12'h000;
    end else begin
      flt_q <= flt;
      for (int i = 0; i < 3; i++) begin
        if (on[i])
          off_cnt[i] <= 8'h00;
        else if (!flt[i])
          off_cnt[i] <= off_cnt[i] + 8'h01;
        if (on[i] && flt[i])
          was_high[i] <= 1'b0;
        else if (hi[i])
          was_high[i] <= 1'b1;
        // each phase against one half-bus reference
        if (!flt[i])
          comp_in[i] <= was_high[i];
        else if (wait_cnt == 12'h001)
          comp_in[i] <= ~was_high[i];
      end
      if (flt != flt_q && $countones(flt) == 1)
        wait_cnt <= cross_delay;
      else if (wait_cnt != 12'h000)
        wait_cnt <= wait_cnt - 12'h001;
    end
  end
endmodule
`default_nettype wire

//--- tb/commutator_properties.sv
// port-level assertions for the six-step commutator
`timescale 1ns/1ps
`default_nettype none
module commutator_properties
  import commutator_pkg::*;
(
  // clock and reset
  input wire logic                        clock,
  input wire logic                        nrst,
  // watched ports
  input wire logic                        stop,
  input wire logic                        reverse,
  input wire logic                        fault_trip,
  input wire commutator_pkg::gate_drive_t gates,
  input wire logic                        running,
  input wire logic                        locked,
  input wire logic [2:0]                  step,
  input wire logic                        commutate
);
  logic [2:0] pon;
  logic [2:0] short;
  logic [1:0] fidx;
  logic [4:0] gap [3];

  assign pon = {gates.c_hi | gates.c_lo, gates.b_hi | gates.b_lo,
                gates.a_hi | gates.a_lo};
  assign fidx = 2'd2 - 2'(step % 3'd3);
  always_comb
    for (int i = 0; i < 3; i++) short[i] = gap[i] < 5'(DEAD_CYCLES);
  // both-off run per pair, saturating so long idle spells stay legal
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      gap <= '{default: 5'h00};
    else
      for (int i = 0; i < 3; i++)
        gap[i] <= pon[i] ? 5'h00 : gap[i] + 5'(gap[i] != 5'h1F);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  trip_gates_off_a: assert property (
    fault_trip |-> gates == GATES_OFF) else $error("gates on in trip");
  trip_idles_a: assert property (
    fault_trip [*4] |-> !running) else $error("trip left it running");
  deadband_gap_a: assert property (
    (pon & ~$past(pon) & short) == 3'h0) else $error("deadband short");
  step_forward_a: assert property (
    commutate && $past(running) && !reverse |-> step ==
    ($past(step) == STEP_LAST ? STEP_AB : $past(step) + 3'h1))
    else $error("forward step order broken");
  step_reverse_a: assert property (
    commutate && $past(running) && reverse |-> step ==
    ($past(step) == STEP_AB ? STEP_LAST : $past(step) - 3'h1))
    else $error("reverse step order broken");
  step_pulse_a: assert property (
    running && $past(running) && step != $past(step) |-> commutate)
    else $error("step moved without pulse");
  float_off_a: assert property (
    running && $past(running, 3) && $stable(step) &&
    step == $past(step, 3) |-> !pon[fidx])
    else $error("floating phase driven");
  stop_idle_a: assert property (
    stop |=> !running) else $error("stop ignored");

  lock_seen_c: cover property ($rose(locked));
  rev_comm_c: cover property (commutate && reverse);
  trip_run_c: cover property (fault_trip && running);
endmodule

bind sensorless_six_step_commutator commutator_properties chk (
  .clock(clock), .nrst(nrst), .stop(stop), .reverse(reverse),
  .fault_trip(fault_trip), .gates(gates), .running(running),
  .locked(locked), .step(step), .commutate(commutate));
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the six-step commutator
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import commutator_pkg::*;
  localparam int unsigned RS = 2000;
  localparam int unsigned RE = 400;
  logic               clock, nrst, start, stop, reverse, fault_trip;
  logic               running, locked, commutate;
  logic [PWM_W-1:0]   duty;
  logic [TIMER_W-1:0] blank_cycles;
  logic [11:0]        cross_delay;
  logic [2:0]         comp_in, step;
  gate_drive_t        gates;
  int unsigned        fails, checks_done, cyc, last_c, ival;

  sensorless_six_step_commutator #(
    .RAMP_START (TIMER_W'(RS)),
    .RAMP_END   (TIMER_W'(RE))
  ) uut (
    .clock(clock), .nrst(nrst), .start(start), .stop(stop),
    .reverse(reverse), .duty(duty), .blank_cycles(blank_cycles),
    .fault_trip(fault_trip), .comp_in(comp_in), .gates(gates),
    .running(running), .locked(locked), .step(step),
    .commutate(commutate));
  bridge_motor_model model (
    .clock(clock), .nrst(nrst), .cross_delay(cross_delay),
    .gates(gates), .comp_in(comp_in));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // cycle count, commutation interval and hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (commutate === 1'b1) begin
      ival   <= cyc - last_c;
      last_c <= cyc;
    end
    if (cyc == 80000) begin
      fails++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic wait_comm();
    int k;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (commutate !== 1'b1 && k < 4000);
    // one more edge so the interval monitor has taken the pulse
    tick(1);
  endtask

  task automatic launch(input logic dir, input logic [11:0] dly);
    reverse      = dir;
    cross_delay  = dly;
    duty         = PWM_W'($urandom_range(990, 900));
    blank_cycles = TIMER_W'($urandom_range(40, 8));
    start        = 1'b1;
    tick(1);
    start        = 1'b0;
    check(running, 1'b1, "running");
  endtask

  function automatic int unsigned ramp_next(input int unsigned p);
    return (p > RE) ? p - (p >> RAMP_SHIFT) : p;
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    int unsigned p, tx, i;
    logic [1:0]  fi;
    logic [2:0]  c0;
    void'($urandom(68));
    {nrst, start, stop, reverse, fault_trip} = 5'h00;
    duty = '0;
    blank_cycles = '0;
    cross_delay = '0;
    {fails, checks_done, cyc, last_c, ival} = '0;
    tick(3);
    nrst = 1'b1;
    check(gates, GATES_OFF, "gates");
    check(step, STEP_AB, "step");
    check(running, 1'b0, "running");
    // open-loop ramp, motor still too slow for back-emf
    launch(1'b0, 12'h000);
    wait_comm();
    check(step, 3'h1, "step");
    p = RS;
    for (i = 0; i < 6; i++) begin
      wait_comm();
      p = ramp_next(p);
      check(ival, p, "ramp period");
      check(step, 3'((i + 2) % 6), "step");
      check(locked, 1'b0, "locked");
    end
    fault_trip = 1'b1;
    #1;
    check(gates, GATES_OFF, "gates");
    tick(4);
    check(running, 1'b0, "running");
    fault_trip = 1'b0;
    tick(8);
    // reverse run that locks onto the crossings
    // crossings held back until the hand-over fits the stall guard
    launch(1'b1, 12'h000);
    wait_comm();
    check(step, STEP_LAST, "step");
    repeat (18) wait_comm();
    cross_delay = 12'($urandom_range(170, 130));
    for (i = 0; i < 40 && locked !== 1'b1; i++) wait_comm();
    check(locked, 1'b1, "locked");
    for (i = 0; i < 4; i++) begin
      wait_comm();
      fi = 2'd2 - 2'(step % 3'd3);
      c0 = comp_in;
      for (tx = 0; tx < 900 && comp_in[fi] === c0[fi]; tx++) tick(1);
      p  = ival;
      tx = cyc;
      wait_comm();
      check((cyc - tx - p / 2) inside {[2:5]}, 1'b1, "delay");
    end
    // crossings vanish: the stall guard drops back to idle
    cross_delay = 12'h000;
    tick(2000);
    check(running, 1'b0, "running");
    launch(1'b0, 12'($urandom_range(170, 130)));
    repeat (2) wait_comm();
    stop = 1'b1;
    tick(1);
    check(running, 1'b0, "running");
    stop = 1'b0;
    tick(1);
    launch(1'b0, 12'($urandom_range(170, 130)));
    repeat (3) wait_comm();
    nrst = 1'b0;
    tick(1);
    check(gates, GATES_OFF, "gates");
    check(step, STEP_AB, "step");
    check(locked, 1'b0, "locked");
    tick(2);
    nrst = 1'b1;
    tick(5);
    conclude();
  end
endmodule
`default_nettype wire
